// *** low_power_state_control.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Held clock-stop request moves the core from running into Stop Grant.
// - Entering Stop Grant from running issues one Stop Grant Acknowledge transaction.
// - Stop Grant gates core clocks except bus and interrupt units.
// - Stop Grant still services snoops and interrupts.
// - Removing clock-stop re-enables all clocks and resumes execution.
// - Clock-stop never touches the bus clock; only core clocks gate.
// - Sleep request is honoured only in Stop Grant, entering Sleep.
// - Sleep stops every unit clock; only the PLL keeps running.
// - Sleep ignores snoops and interrupts; only sleep, thermal, reset count.
// - Sleep request removal returns to Stop Grant, restarting bus clocks.
// - Management interrupt saves state, enters mode, acknowledges, runs.
// - In management mode, memory indicator drives on request clock two.
// - Thermal trip halts execution and latches the trip output.
// - Reset clears the thermal stop only once the sensor is cool.
// - Reset drops bus outputs within two clocks and returns to running.
module low_power_state_control
    import lpsc_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic       i_clk_en,
    input  wire logic       i_clock_stop_request_n,
    input  wire logic       i_sleep_request_n,
    input  wire logic       i_mgmt_interrupt_n,
    input  wire logic       i_thermal_over_temp,
    input  wire logic       i_snoop_req,
    input  wire logic       i_interrupt_req,
    input  wire logic       i_bus_grant,
    input  wire logic       i_core_req,
    input  wire logic       i_mgmt_exit,
    input  wire logic       i_mgmt_ram_fetch,
    output logic            o_core_clk_en,
    output logic            o_bus_unit_clk_en,
    output logic            o_intc_clk_en,
    output logic            o_executing,
    output logic            o_save_state,
    output logic            o_mgmt_handler_start,
    output logic            o_management_mode,
    output logic            o_req_valid,
    output logic            o_req_phase2,
    output logic [1:0]      o_ack_code,
    output logic            o_extended_function_line_4,
    output logic            o_snoop_ack,
    output logic            o_interrupt_taken,
    output logic            o_thermal_trip_n,
    output logic [1:0]      o_power_state
);

    lpsc_sync_if sync ();

    lpsc_input_sync u_sync (
        .i_clock                (i_clock),
        .i_rst_b                (i_rst_b),
        .i_clk_en               (i_clk_en),
        .i_clock_stop_request_n (i_clock_stop_request_n),
        .i_sleep_request_n      (i_sleep_request_n),
        .i_mgmt_interrupt_n     (i_mgmt_interrupt_n),
        .i_thermal_over_temp    (i_thermal_over_temp),
        .sync                   (sync)
    );

    // Kinds of request the bus phase carries.
    typedef enum logic [1:0] {
        RQ_NONE,
        RQ_ACK_STOP,
        RQ_ACK_MGMT,
        RQ_CORE
    } req_kind_t;

    typedef struct packed {
        power_state_t state;
        logic         thermal_latched;
        logic         mgmt_mode;
        logic         mgmt_pending;
        logic         stop_ack_pending;
        logic         rst_seen;
        req_kind_t    req_kind;
        logic         req_active;
        logic         req_second;
        logic         req_mgmt_ram;
        logic         core_clk_en;
        logic         bus_clk_en;
        logic         intc_clk_en;
        logic         executing;
        logic         save_state;
        logic         handler_start;
        logic         snoop_ack;
        logic         int_taken;
        logic         trip_n;
        logic [1:0]   ack_code;
        logic         ext_n;
    } ctl_state_t;

    ctl_state_t st_r;
    ctl_state_t st_nxt;

    // Maps the request kind to the acknowledge code driven on the bus.
    function automatic logic [1:0] ack_of(input req_kind_t k);
        case (k)
            RQ_ACK_STOP: ack_of = ACK_STOPGRANT;
            RQ_ACK_MGMT: ack_of = ACK_MGMT;
            default:     ack_of = ACK_NONE;
        endcase
    endfunction

    // Tells whether a state lets the core run its units.
    function automatic logic is_running(input power_state_t s);
        is_running = (s == ST_RUN);
    endfunction

    // Next-state logic. The thermal check comes first in Run and Stop Grant; in Sleep a
    // dropped sleep request wins, and the hot die halts a clock later from Stop Grant.
    always_comb begin
        st_nxt = st_r;
        st_nxt.save_state    = 1'h0;
        st_nxt.handler_start = 1'h0;
        st_nxt.snoop_ack     = 1'h0;
        st_nxt.int_taken     = 1'h0;
        st_nxt.rst_seen      = 1'h1;

        // After reset release a still-hot die relatches the trip once the
        // synchroniser passes it on, so reset clears the stop only once cool.
        if (!st_r.rst_seen && sync.thermal_hot) begin
            st_nxt.thermal_latched = 1'h1;
        end
        if (sync.thermal_hot) begin
            st_nxt.thermal_latched = 1'h1;
        end

        // Power state sequencing.
        case (st_r.state)
            ST_RUN: begin
                if (st_nxt.thermal_latched) begin
                    st_nxt.state = ST_THERMAL;
                end else if (sync.clock_stop_req) begin
                    st_nxt.state = ST_STOPGRANT;
                    st_nxt.stop_ack_pending = 1'h1;
                end else if (sync.mgmt_int_req && !st_r.mgmt_mode) begin
                    st_nxt.save_state   = 1'h1;
                    st_nxt.mgmt_mode    = 1'h1;
                    st_nxt.mgmt_pending = 1'h1;
                end
            end
            ST_STOPGRANT: begin
                if (st_nxt.thermal_latched) begin
                    st_nxt.state = ST_THERMAL;
                end else if (!sync.clock_stop_req) begin
                    st_nxt.state = ST_RUN;
                end else if (sync.sleep_req && !st_r.stop_ack_pending) begin
                    st_nxt.state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Only the sleep request and the thermal latch are looked at here.
                if (!sync.sleep_req) begin
                    st_nxt.state = ST_STOPGRANT;
                end else if (st_nxt.thermal_latched) begin
                    st_nxt.state = ST_THERMAL;
                end
            end
            ST_THERMAL: begin
                st_nxt.state = ST_THERMAL;
            end
            default: begin
                st_nxt.state = ST_RUN;
            end
        endcase

        if (i_mgmt_exit && st_r.mgmt_mode && is_running(st_r.state)) begin
            st_nxt.mgmt_mode = 1'h0;
        end

        // Snoops and interrupts are served while running or in Stop Grant,
        // never in Sleep or after a thermal stop.
        if (st_r.state == ST_RUN || st_r.state == ST_STOPGRANT) begin
            st_nxt.snoop_ack = i_snoop_req;
            st_nxt.int_taken = i_interrupt_req;
        end

        // Bus request phase, two clocks long. Acknowledges win the bus ahead of core traffic,
        // but wait for a phase already under way, and Sleep waits until the Stop Grant ack phase has started.
        if (st_r.req_active) begin
            if (st_r.req_second) begin
                st_nxt.req_active = 1'h0;
                st_nxt.req_second = 1'h0;
                st_nxt.req_kind   = RQ_NONE;
                if (st_r.req_kind == RQ_ACK_MGMT) begin
                    st_nxt.handler_start = 1'h1;
                end
            end else begin
                st_nxt.req_second = 1'h1;
            end
        end else if (i_bus_grant && st_r.state != ST_SLEEP
                     && st_r.state != ST_THERMAL) begin
            if (st_r.stop_ack_pending) begin
                st_nxt.req_active       = 1'h1;
                st_nxt.req_kind         = RQ_ACK_STOP;
                st_nxt.stop_ack_pending = 1'h0;
                st_nxt.req_mgmt_ram     = 1'h0;
            end else if (st_r.mgmt_pending) begin
                st_nxt.req_active   = 1'h1;
                st_nxt.req_kind     = RQ_ACK_MGMT;
                st_nxt.mgmt_pending = 1'h0;
                st_nxt.req_mgmt_ram = 1'h0;
            end else if (i_core_req && is_running(st_r.state)) begin
                st_nxt.req_active   = 1'h1;
                st_nxt.req_kind     = RQ_CORE;
                st_nxt.req_mgmt_ram = st_r.mgmt_mode
                                      && i_mgmt_ram_fetch;
            end
        end

        // Clock gating follows the next state. The bus clock itself is not
        // generated here, so clock-stop cannot disturb it.
        st_nxt.core_clk_en = is_running(st_nxt.state);
        st_nxt.bus_clk_en  = (st_nxt.state == ST_RUN)
                             || (st_nxt.state == ST_STOPGRANT);
        st_nxt.intc_clk_en = st_nxt.bus_clk_en;
        st_nxt.executing   = is_running(st_nxt.state)
                             && !st_nxt.thermal_latched;
        st_nxt.trip_n      = ~st_nxt.thermal_latched;
        // Bus codes are registered so no decode sits behind a pin.
        st_nxt.ack_code    = ack_of(st_nxt.req_kind);
        st_nxt.ext_n       = (st_nxt.req_active && st_nxt.req_second
                              && st_nxt.req_mgmt_ram)
                             ? ~RST_MGMT_MEM_N
                             : RST_MGMT_MEM_N;
    end

    // Reset drops every bus output at once, without waiting for a clock, and returns to
    // running; the trip latch alone is rebuilt from the cool sensor.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r                 <= '0;
            st_r.state           <= ST_RUN;
            st_r.core_clk_en     <= 1'h1;
            st_r.bus_clk_en      <= 1'h1;
            st_r.intc_clk_en     <= 1'h1;
            st_r.executing       <= 1'h1;
            st_r.trip_n          <= RST_THERMAL_TRIP_N;
            st_r.ack_code        <= ACK_NONE;
            st_r.ext_n           <= RST_MGMT_MEM_N;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    // All outputs come straight from the state register.
    assign o_core_clk_en        = st_r.core_clk_en;
    assign o_bus_unit_clk_en    = st_r.bus_clk_en;
    assign o_intc_clk_en        = st_r.intc_clk_en;
    assign o_executing          = st_r.executing;
    assign o_save_state         = st_r.save_state;
    assign o_mgmt_handler_start = st_r.handler_start;
    assign o_management_mode    = st_r.mgmt_mode;
    assign o_req_valid          = st_r.req_active;
    assign o_req_phase2         = st_r.req_second;
    assign o_ack_code           = st_r.ack_code;
    // Low-active indicator, driven only in the second request clock.
    assign o_extended_function_line_4 = st_r.ext_n;
    assign o_snoop_ack          = st_r.snoop_ack;
    assign o_interrupt_taken    = st_r.int_taken;
    assign o_thermal_trip_n     = st_r.trip_n;
    assign o_power_state        = st_r.state;

endmodule

// *** lpsc_pkg.sv ***
package lpsc_pkg;

    // Depth of each input synchroniser.
    localparam int unsigned SYNC_STAGES = 2;

    // Time allowed for bus outputs to fall after reset, in bus clocks.
    localparam int unsigned RESET_OUT_CLOCKS = 2;

    // Length of a request phase on the bus, in clocks.
    localparam int unsigned REQ_PHASE_CLOCKS = 2;

    // Acknowledge transaction codes put out on o_ack_code.
    localparam logic [1:0] ACK_NONE      = 2'h0;
    localparam logic [1:0] ACK_STOPGRANT = 2'h1;
    localparam logic [1:0] ACK_MGMT      = 2'h2;

    // Reset values of the pins; the active-low pins idle high.
    localparam logic RST_THERMAL_TRIP_N = 1'h1;
    localparam logic RST_MGMT_MEM_N     = 1'h1;

    // Power states of the core.
    typedef enum logic [1:0] {
        ST_RUN,
        ST_STOPGRANT,
        ST_SLEEP,
        ST_THERMAL
    } power_state_t;

endpackage

// *** lpsc_sync_if.sv ***
`timescale 1ns/1ns
// Synchronised request levels that pass from the synchroniser to the core.
interface lpsc_sync_if;
    logic clock_stop_req;
    logic sleep_req;
    logic mgmt_int_req;
    logic thermal_hot;

    modport src (output clock_stop_req, output sleep_req,
                 output mgmt_int_req, output thermal_hot);
    modport dst (input clock_stop_req, input sleep_req,
                 input mgmt_int_req, input thermal_hot);
endinterface

// *** lpsc_input_sync.sv ***
`timescale 1ns/1ns
module lpsc_input_sync
    import lpsc_pkg::*;
(
    input  wire logic  i_clock,
    input  wire logic  i_rst_b,
    input  wire logic  i_clk_en,
    input  wire logic  i_clock_stop_request_n,
    input  wire logic  i_sleep_request_n,
    input  wire logic  i_mgmt_interrupt_n,
    input  wire logic  i_thermal_over_temp,
    lpsc_sync_if.src   sync
);

    typedef struct packed {
        logic [3:0] stage1;
        logic [3:0] stage2;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;
    logic [3:0]  raw;

    // Requests are turned active high before sampling.
    assign raw = {i_thermal_over_temp, ~i_mgmt_interrupt_n,
                  ~i_sleep_request_n, ~i_clock_stop_request_n};

    // Stage one is read only by stage two, to contain metastability.
    always_comb begin
        st_nxt = st_r;
        if (i_clk_en) begin
            st_nxt.stage1 = raw;
            st_nxt.stage2 = st_r.stage1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync.clock_stop_req = st_r.stage2[0];
    assign sync.sleep_req      = st_r.stage2[1];
    assign sync.mgmt_int_req   = st_r.stage2[2];
    assign sync.thermal_hot    = st_r.stage2[3];

endmodule

// *** lpsc_props.sv ***
`timescale 1ns/1ns
// Pin-level checker for the power-state block.
module lpsc_props
    import lpsc_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst_b,
    input wire logic       i_clk_en,
    input wire logic       i_clock_stop_request_n,
    input wire logic       i_thermal_over_temp,
    input wire logic       i_snoop_req,
    input wire logic       i_interrupt_req,
    input wire logic       i_bus_grant,
    input wire logic       o_core_clk_en,
    input wire logic       o_bus_unit_clk_en,
    input wire logic       o_intc_clk_en,
    input wire logic       o_executing,
    input wire logic       o_save_state,
    input wire logic       o_management_mode,
    input wire logic       o_req_valid,
    input wire logic       o_req_phase2,
    input wire logic [1:0] o_ack_code,
    input wire logic       o_extended_function_line_4,
    input wire logic       o_snoop_ack,
    input wire logic       o_interrupt_taken,
    input wire logic       o_thermal_trip_n,
    input wire logic [1:0] o_power_state
);
    // Everything is judged on the bus clock and, except the reset check, is quiet during reset.
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    a_grant_gates_core: assert property (
        o_power_state == 2'h1 |-> !o_core_clk_en && !o_executing
            && o_bus_unit_clk_en && o_intc_clk_en) else $error("grant clocks");
    a_sleep_stops_all: assert property (
        o_power_state == 2'h2 |-> !o_core_clk_en && !o_bus_unit_clk_en
            && !o_intc_clk_en) else $error("sleep clocks");
    // The synchroniser must hide a new request for at least one edge.
    a_sync_hides_edge: assert property (
        o_power_state == 2'h0 && o_thermal_trip_n
            && $fell(i_clock_stop_request_n) |=> o_power_state == 2'h0)
        else $error("request acted too early");
    a_stop_enters: assert property (
        (o_power_state == 2'h0 && o_thermal_trip_n
            && $fell(i_clock_stop_request_n)) ##0 (i_clk_en
            && !i_clock_stop_request_n && !i_thermal_over_temp) [*5]
        |-> o_power_state == 2'h1) else $error("no stop grant");
    a_no_sleep_run: assert property (
        o_power_state == 2'h0 |=> o_power_state != 2'h2)
        else $error("sleep from run");
    a_sleep_deaf: assert property (
        o_power_state == 2'h2 && (i_snoop_req || i_interrupt_req)
            |=> !o_snoop_ack && !o_interrupt_taken) else $error("sleep acked");
    a_grant_serves: assert property (
        o_power_state == 2'h1 && i_snoop_req && i_interrupt_req
            |=> o_snoop_ack && o_interrupt_taken) else $error("grant deaf");
    a_sga_issued: assert property (
        o_power_state == 2'h1 && $past(o_power_state) == 2'h0 && i_bus_grant
            |-> ##[0:6] (o_req_valid && o_ack_code == ACK_STOPGRANT))
        else $error("no stop grant ack");
    a_mgmt_acked: assert property (
        $rose(o_save_state) |-> o_management_mode
            ##[1:8] (o_req_valid && o_ack_code == ACK_MGMT))
        else $error("no mgmt ack");
    a_ext_line_mode: assert property (
        !o_extended_function_line_4 |-> o_req_phase2 && o_management_mode)
        else $error("indicator misplaced");
    a_trip_latched: assert property (
        !o_thermal_trip_n |=> !o_thermal_trip_n) else $error("trip dropped");
    a_reset_quiets: assert property (
        @(posedge i_clock) disable iff (1'b0)
        !i_rst_b |-> !o_req_valid && o_power_state == 2'h0)
        else $error("outputs live in reset");
endmodule

bind low_power_state_control lpsc_props u_lpsc_props (.*);

// *** lpsc_system_model.sv ***
`timescale 1ns/1ns
// System logic raising the power requests as active-low pins.
module lpsc_system_model (
    input  wire logic i_stop,
    input  wire logic i_sleep,
    input  wire logic i_mgmt,
    output logic      o_stop_n,
    output logic      o_sleep_n,
    output logic      o_mgmt_n
);
    // Pins idle inactive so nothing is pending when reset ends.
    initial begin
        o_stop_n = 1'h1;
        o_sleep_n = 1'h1;
        o_mgmt_n = 1'h1;
    end

    // A 3 ns skew puts pin changes away from any clock edge.
    always @(i_stop) o_stop_n <= #3 !i_stop;
    always @(i_sleep) o_sleep_n <= #3 !i_sleep;
    always @(i_mgmt) o_mgmt_n <= #3 !i_mgmt;
endmodule

// *** tb_low_power_state_control.sv ***
`timescale 1ns/1ns
// Self-checking bench for the power-state block.
module tb_low_power_state_control;
    import lpsc_pkg::*;
    logic i_clock, i_rst_b, i_clk_en, i_thermal_over_temp, i_snoop_req;
    logic i_interrupt_req, i_bus_grant, i_core_req, i_mgmt_exit;
    logic i_mgmt_ram_fetch, want_stop, want_sleep, want_mgmt;
    logic i_clock_stop_request_n, i_sleep_request_n, i_mgmt_interrupt_n;
    logic o_core_clk_en, o_bus_unit_clk_en, o_intc_clk_en, o_executing;
    logic o_save_state, o_mgmt_handler_start, o_management_mode;
    logic o_req_valid, o_req_phase2, o_extended_function_line_4;
    logic o_snoop_ack, o_interrupt_taken, o_thermal_trip_n;
    logic [1:0] o_ack_code, o_power_state;
    int errors = 0;
    int total_checks = 0;

    low_power_state_control u_low_power_state_control (.*);
    lpsc_system_model u_lpsc_system_model (
        .i_stop(want_stop), .i_sleep(want_sleep), .i_mgmt(want_mgmt),
        .o_stop_n(i_clock_stop_request_n), .o_sleep_n(i_sleep_request_n),
        .o_mgmt_n(i_mgmt_interrupt_n));

    // Bus clock, 8 ns period.
    initial begin
        i_clock = 1'h0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compares a result of up to two bits; four-state safe.
    task automatic check(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    // Bounded wait for a power state; a hang ends the run.
    task automatic wait_state(input logic [1:0] s);
        for (int k = 0; k < 20 && o_power_state !== s; k++) tick(1);
        check(o_power_state, s);
        if (o_power_state !== s) report_and_stop();
    endtask

    // Waits for a request phase, then checks its code and second clock.
    task automatic wait_phase(input logic [1:0] code, input logic ext);
        for (int k = 0; k < 12 && o_req_valid !== 1'h1; k++) tick(1);
        check(o_req_valid, 1'h1);
        if (o_req_valid !== 1'h1) report_and_stop();
        i_core_req = 1'h0;
        check(o_ack_code, code);
        tick(1);
        check(o_req_phase2, 1'h1);
        check(o_extended_function_line_4, ext);
        tick(1);
    endtask

    // One snoop and one interrupt, answered a clock later or not at all.
    task automatic poke(input logic exp);
        i_snoop_req = 1'h1;
        i_interrupt_req = 1'h1;
        tick(1);
        i_snoop_req = 1'h0;
        i_interrupt_req = 1'h0;
        check(o_snoop_ack, exp);
        check(o_interrupt_taken, exp);
    endtask

    task automatic do_reset();
        i_rst_b = 1'h0;
        tick(10);
        check(o_req_valid, 1'h0);
        check(o_power_state, ST_RUN);
        i_rst_b = 1'h1;
    endtask

    task automatic t_mgmt();
        want_mgmt = 1'h1;
        wait_phase(ACK_MGMT, 1'h1);
        check(o_management_mode, 1'h1);
        check(o_mgmt_handler_start, 1'h1);
        want_mgmt = 1'h0;
        i_mgmt_ram_fetch = 1'h1;
        i_core_req = 1'h1;
        wait_phase(ACK_NONE, 1'h0);
        i_mgmt_exit = 1'h1;
        tick(1);
        i_mgmt_exit = 1'h0;
        tick(1);
        check(o_management_mode, 1'h0);
        i_core_req = 1'h1;
        wait_phase(ACK_NONE, 1'h1);
        i_mgmt_ram_fetch = 1'h0;
    endtask

    task automatic t_stop_grant();
        want_stop = 1'h1;
        tick(2);
        check(o_power_state, ST_RUN);
        wait_phase(ACK_STOPGRANT, 1'h1);
        check(o_power_state, ST_STOPGRANT);
        check(o_core_clk_en, 1'h0);
        check(o_bus_unit_clk_en, 1'h1);
        poke(1'h1);
        want_stop = 1'h0;
        wait_state(ST_RUN);
        check(o_executing, 1'h1);
        check(o_core_clk_en, 1'h1);
    endtask

    task automatic t_sleep();
        want_sleep = 1'h1;
        tick(6);
        check(o_power_state, ST_RUN);
        want_stop = 1'h1;
        wait_state(ST_SLEEP);
        check(o_bus_unit_clk_en, 1'h0);
        check(o_intc_clk_en, 1'h0);
        poke(1'h0);
        want_sleep = 1'h0;
        wait_state(ST_STOPGRANT);
        check(o_bus_unit_clk_en, 1'h1);
        want_stop = 1'h0;
        wait_state(ST_RUN);
    endtask

    // A low clock enable must hold every stage, synchronisers included.
    task automatic t_freeze();
        i_clk_en = 1'h0;
        want_stop = 1'h1;
        tick(6);
        check(o_power_state, ST_RUN);
        i_clk_en = 1'h1;
        wait_state(ST_STOPGRANT);
        want_stop = 1'h0;
        wait_state(ST_RUN);
    endtask

    task automatic t_thermal();
        i_thermal_over_temp = 1'h1;
        wait_state(ST_THERMAL);
        check(o_thermal_trip_n, 1'h0);
        check(o_executing, 1'h0);
        i_thermal_over_temp = 1'h0;
        tick(5);
        check(o_thermal_trip_n, 1'h0);
        i_thermal_over_temp = 1'h1;
        do_reset();
        wait_state(ST_THERMAL);
        i_thermal_over_temp = 1'h0;
        do_reset();
        tick(6);
        check(o_thermal_trip_n, 1'h1);
        check(o_power_state, ST_RUN);
    endtask

    // Main sequence; inputs change on falling edges, the request pins 3 ns after them.
    initial begin
        {i_thermal_over_temp, i_snoop_req, i_interrupt_req} = 3'h0;
        {i_core_req, i_mgmt_exit, i_mgmt_ram_fetch} = 3'h0;
        {want_stop, want_sleep, want_mgmt} = 3'h0;
        i_clk_en = 1'h1;
        i_bus_grant = 1'h1;
        do_reset();
        tick(4);
        t_mgmt();
        t_stop_grant();
        t_sleep();
        t_freeze();
        t_thermal();
        report_and_stop();
    end
endmodule
